// ---- src/hp_pkg.sv ----
// constants, register map and shared types of the heat pump sequencer
package hp_pkg;
	// timebase
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_PERIOD_MS = 100;
	localparam int TICK_CYCLES = TICK_PERIOD_MS * 1_000_000 / CLK_PERIOD_NS;
	localparam int TICK_W = 24;
	localparam int SEC_MS = 1000;
	localparam int MIN_S = 60;
	localparam int TICKS_PER_SEC = SEC_MS / TICK_PERIOD_MS;
	localparam int MIN_TICKS = MIN_S * TICKS_PER_SEC;
	// speed-up: one minute of period becomes 100 ms
	localparam int FAST_MIN_MS = 100;
	localparam int FAST_MIN_TICKS = FAST_MIN_MS / TICK_PERIOD_MS;

	// defrost timing
	localparam int CNT_W = 17;
	localparam int RUN_STEP_MIN = 30;
	localparam int DEF_LIMIT_MIN = 10;
	localparam int FORCED_DEF_S = 30;
	localparam logic [CNT_W-1:0] FORCED_DEF_TICKS =
		CNT_W'(FORCED_DEF_S * TICKS_PER_SEC);

	// jumper short classification, inclusive bounds in ticks
	localparam int JMP_W = 8;
	localparam int SHORT_MIN_S = 1;
	localparam int SHORT_MAX_S = 3;
	localparam int LONG_MIN_S = 5;
	localparam int LONG_MAX_S = 20;
	localparam logic [JMP_W-1:0] SHORT_MIN_T =
		JMP_W'(SHORT_MIN_S * TICKS_PER_SEC);
	localparam logic [JMP_W-1:0] SHORT_MAX_T =
		JMP_W'(SHORT_MAX_S * TICKS_PER_SEC);
	localparam logic [JMP_W-1:0] LONG_MIN_T =
		JMP_W'(LONG_MIN_S * TICKS_PER_SEC);
	localparam logic [JMP_W-1:0] LONG_MAX_T =
		JMP_W'(LONG_MAX_S * TICKS_PER_SEC);
	localparam logic [JMP_W-1:0] JMP_SAT = 8'hFF;

	// register map
	localparam logic [31:0] CFG_OFS = 32'h0000_0000;
	localparam logic [31:0] STATUS_OFS = 32'h0000_0004;
	localparam logic [31:0] RUNCNT_OFS = 32'h0000_0008;
	localparam int CFG_SEL_LSB = 0;
	localparam int CFG_SEL_W = 2;
	localparam logic [CFG_SEL_W-1:0] CFG_SEL_RESET = 2'h1;
	localparam int STAT_MODE_LSB = 0;
	localparam int STAT_VALVE_BIT = 4;
	localparam int STAT_ACCEL_BIT = 5;
	localparam int STAT_FORCED_BIT = 6;
	localparam int STAT_FROST_BIT = 7;

	// bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic HRESP_OKAY = 1'b0;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h1,
		ST_COOL = 4'h2,
		ST_HEAT = 4'h4,
		ST_DEF = 4'h8
	} mode_t;
endpackage

// ---- src/speedup_if.sv ----
// link between the sequencer core and the jumper timer
interface speedup_if;
	logic tick;
	logic short_det;
	logic accel_req;
	logic forced_req;

	modport timer (
		input tick,
		input short_det,
		output accel_req,
		output forced_req
	);
	modport core (
		output tick,
		output short_det,
		input accel_req,
		input forced_req
	);
endinterface

// ---- src/speedup_timer.sv ----
// measures a speed-up jumper short and classifies it on release
module speedup_timer
	import hp_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// core link
	speedup_if.timer su
);
	typedef struct packed {
		logic [JMP_W-1:0] cnt;
		logic prev;
		logic accel_req;
		logic forced_req;
	} tmr_t;

	tmr_t s_r;
	tmr_t s_nxt;

	always_comb
	begin
		s_nxt = s_r;
		if (ce_in)
		begin
			s_nxt.accel_req = 1'b0;
			s_nxt.forced_req = 1'b0;
			s_nxt.prev = su.short_det;
			// resolution is one tick; saturates so long holds stay invalid
			if (su.short_det && su.tick && s_r.cnt != JMP_SAT)
				s_nxt.cnt = s_r.cnt + 8'h01;
			if (s_r.prev && !su.short_det)
			begin
				s_nxt.cnt = '0;
				if (s_r.cnt >= SHORT_MIN_T && s_r.cnt <= SHORT_MAX_T)
					s_nxt.accel_req = 1'b1;
				else if (s_r.cnt >= LONG_MIN_T && s_r.cnt <= LONG_MAX_T)
					s_nxt.forced_req = 1'b1;
				// other durations fall through untouched
			end
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign su.accel_req = s_r.accel_req;
	assign su.forced_req = s_r.forced_req;
endmodule

// ---- src/heat_pump_defrost_sequencer.sv ----
// heat pump compressor, reversing valve and defrost sequencer
// Operation
// - valve on in cooling, off in heating
// - valve position from internal state only
// - valve held on until new heat demand
// - valve held off until next cooling
// - decode demands into compressor starts
// - no defrost during continuous run period
// - run period 30/60/90/120 from selects
// - run period defaults to 60 minutes
// - frost switch open at expiry: rerun period
// - frost switch closed at expiry: defrost
// - defrost ends on switch open or 10 min
// - after defrost, full period from zero
// - heat drop while heating keeps count; resume later
// - 1-3 s short: minute becomes 0.1 s
// - accelerated: one heat, one defrost, exit
// - 5-20 s short: forced defrost now
// - forced, switch closed: normal defrost
// - forced, switch open: 30 s defrost
// - electric heat on during defrost
module heat_pump_defrost_sequencer
	import hp_pkg::*;
#(
	parameter int TICK_CYCLES_P = hp_pkg::TICK_CYCLES
)
(
	// clock, reset, enable
	input wire logic clk_in,
	input wire logic rst_n_in,
	input wire logic ce_in,
	// ahb-lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out,
	// thermostat demands and coil switch
	input wire logic cool_stage1_demand_in,
	input wire logic cool_stage2_demand_in,
	input wire logic heat_stage1_demand_in,
	input wire logic aux_heat_demand_in,
	input wire logic coil_frost_switch_in,
	// speed-up jumper pins, high when shorted together
	input wire logic speedup_pin_a_in,
	input wire logic speedup_pin_b_in,
	// unit outputs
	output logic valve_coil_out,
	output logic compressor1_out,
	output logic compressor2_out,
	output logic outdoor_fan_out,
	output logic electric_heat_out
);
	import hp_pkg::*;

	typedef struct packed {
		mode_t st;
		logic valve;
		logic [CNT_W-1:0] run_cnt;
		logic [CNT_W-1:0] def_cnt;
		logic accel;
		logic forced;
		logic forced_fix;
		logic [TICK_W-1:0] tick_cnt;
		logic tick;
		logic [CFG_SEL_W-1:0] sel;
		logic wr_cfg;
		logic [31:0] hrdata;
		logic valve_o;
		logic comp1_o;
		logic comp2_o;
		logic fan_o;
		logic eheat_o;
	} core_t;

	core_t s_r;
	core_t s_nxt;
	logic cool_any;
	logic def_end;
	logic [CNT_W-1:0] period;
	logic [CNT_W-1:0] def_limit;
	logic [CFG_SEL_W-1:0] sel_eff;
	logic [31:0] rd_word;

	speedup_if su ();

	speedup_timer u_timer (
		.clk_in(clk_in),
		.rst_n_in(rst_n_in),
		.ce_in(ce_in),
		.su(su)
	);

	assign su.tick = s_r.tick;
	assign su.short_det = speedup_pin_a_in & speedup_pin_b_in;
	assign cool_any = cool_stage1_demand_in | cool_stage2_demand_in;

	// scaled minute length follows the accelerated flag
	always_comb
	begin
		if (s_r.accel)
		begin
			period = CNT_W'((int'(s_r.sel) + 1) * RUN_STEP_MIN
				* FAST_MIN_TICKS);
			def_limit = CNT_W'(DEF_LIMIT_MIN * FAST_MIN_TICKS);
		end
		else
		begin
			period = CNT_W'((int'(s_r.sel) + 1) * RUN_STEP_MIN
				* MIN_TICKS);
			def_limit = CNT_W'(DEF_LIMIT_MIN * MIN_TICKS);
		end
	end

	// fixed forced defrost ignores the switch; otherwise first of the two
	always_comb
	begin
		if (s_r.forced_fix)
			def_end = s_r.tick
				&& (s_r.def_cnt + 17'h00001 >= FORCED_DEF_TICKS);
		else
			def_end = !coil_frost_switch_in || (s_r.tick
				&& (s_r.def_cnt + 17'h00001 >= def_limit));
	end

	// a read right behind a write to the config word sees the new value
	assign sel_eff = s_r.wr_cfg
		? hwdata_in[CFG_SEL_LSB +: CFG_SEL_W] : s_r.sel;

	always_comb
	begin
		rd_word = 32'h0000_0000;
		if (haddr_in == CFG_OFS)
			rd_word[CFG_SEL_LSB +: CFG_SEL_W] = sel_eff;
		else if (haddr_in == STATUS_OFS)
		begin
			rd_word[STAT_MODE_LSB +: 4] = s_r.st;
			rd_word[STAT_VALVE_BIT] = s_r.valve_o;
			rd_word[STAT_ACCEL_BIT] = s_r.accel;
			rd_word[STAT_FORCED_BIT] = s_r.forced;
			rd_word[STAT_FROST_BIT] = coil_frost_switch_in;
		end
		else if (haddr_in == RUNCNT_OFS)
			rd_word[CNT_W-1:0] = s_r.run_cnt;
	end

	always_comb
	begin
		s_nxt = s_r;
		if (ce_in)
		begin
			// slow timebase
			s_nxt.tick = 1'b0;
			if (s_r.tick_cnt == TICK_W'(TICK_CYCLES_P - 1))
			begin
				s_nxt.tick_cnt = '0;
				s_nxt.tick = 1'b1;
			end
			else
				s_nxt.tick_cnt = s_r.tick_cnt + 24'h000001;

			// bus: zero-wait, reads registered in the address phase
			s_nxt.wr_cfg = 1'b0;
			if (s_r.wr_cfg)
				s_nxt.sel = hwdata_in[CFG_SEL_LSB +: CFG_SEL_W];
			if (hsel_in && hready_in && htrans_in[1])
			begin
				s_nxt.wr_cfg = hwrite_in && haddr_in == CFG_OFS;
				s_nxt.hrdata = hwrite_in ? 32'h0000_0000 : rd_word;
			end

			unique case (s_r.st)
				ST_IDLE:
				begin
					// count is left as it was on purpose
					if (cool_any)
					begin
						s_nxt.st = ST_COOL;
						s_nxt.valve = 1'b1;
					end
					else if (heat_stage1_demand_in)
					begin
						s_nxt.st = ST_HEAT;
						s_nxt.valve = 1'b0;
					end
				end
				ST_COOL:
				begin
					// valve stays energised through the idle that follows
					if (!cool_any)
						s_nxt.st = ST_IDLE;
				end
				ST_HEAT:
				begin
					if (cool_any)
					begin
						s_nxt.st = ST_COOL;
						s_nxt.valve = 1'b1;
					end
					else if (!heat_stage1_demand_in)
						s_nxt.st = ST_IDLE;
					else if (su.forced_req)
					begin
						s_nxt.st = ST_DEF;
						s_nxt.def_cnt = '0;
						s_nxt.forced = 1'b1;
						s_nxt.forced_fix = !coil_frost_switch_in;
					end
					else if (s_r.tick)
					begin
						if (s_r.run_cnt + 17'h00001 >= period)
						begin
							if (coil_frost_switch_in)
							begin
								s_nxt.st = ST_DEF;
								s_nxt.def_cnt = '0;
							end
							else
								s_nxt.run_cnt = '0;
						end
						else
							s_nxt.run_cnt = s_r.run_cnt + 17'h00001;
					end
				end
				ST_DEF:
				begin
					// a lost heat call aborts defrost with a fresh period
					if (cool_any || !heat_stage1_demand_in || def_end)
					begin
						s_nxt.st = cool_any ? ST_COOL
							: heat_stage1_demand_in ? ST_HEAT : ST_IDLE;
						s_nxt.valve = cool_any;
						s_nxt.run_cnt = '0;
						s_nxt.accel = 1'b0;
						s_nxt.forced = 1'b0;
						s_nxt.forced_fix = 1'b0;
					end
					else if (s_r.tick)
						s_nxt.def_cnt = s_r.def_cnt + 17'h00001;
				end
				default:
				begin
					s_nxt.st = ST_IDLE;
				end
			endcase

			// accelerated test restarts one heating period at scale
			if (su.accel_req && s_nxt.st != ST_DEF)
			begin
				s_nxt.accel = 1'b1;
				s_nxt.run_cnt = '0;
			end

			// outputs follow the next mode so they align with it
			s_nxt.valve_o = s_nxt.valve || s_nxt.st == ST_DEF;
			s_nxt.comp1_o = s_nxt.st != ST_IDLE;
			s_nxt.comp2_o = s_nxt.st == ST_COOL
				&& cool_stage2_demand_in;
			s_nxt.fan_o = s_nxt.st == ST_COOL
				|| s_nxt.st == ST_HEAT;
			s_nxt.eheat_o = s_nxt.st == ST_DEF
				|| aux_heat_demand_in;
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_r <= '0;
			s_r.st <= ST_IDLE;
			s_r.sel <= CFG_SEL_RESET;
		end
		else
			s_r <= s_nxt;
	end

	assign hrdata_out = s_r.hrdata;
	assign hreadyout_out = 1'b1;
	assign hresp_out = HRESP_OKAY;
	assign valve_coil_out = s_r.valve_o;
	assign compressor1_out = s_r.comp1_o;
	assign compressor2_out = s_r.comp2_o;
	assign outdoor_fan_out = s_r.fan_o;
	assign electric_heat_out = s_r.eheat_o;

	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);

	valve_cool_a: assert property (s_r.st == ST_COOL |-> valve_coil_out)
		else $error("valve off while cooling");
	valve_heat_a: assert property (s_r.st == ST_HEAT |-> !valve_coil_out)
		else $error("valve on while heating");
	valve_hold_a: assert property (
		(s_r.st == ST_IDLE && $past(s_r.st) == ST_IDLE)
		|-> $stable(valve_coil_out))
		else $error("valve moved while idle");
	comp_cool_a: assert property (
		s_r.st == ST_COOL |-> compressor1_out
		&& (compressor2_out == $past(cool_stage2_demand_in)))
		else $error("compressor wrong while cooling");
	defrost_outs_a: assert property (
		s_r.st == ST_DEF |-> valve_coil_out && compressor1_out
		&& !outdoor_fan_out)
		else $error("defrost output pattern wrong");
	defrost_eheat_a: assert property (s_r.st == ST_DEF |-> electric_heat_out)
		else $error("electric heat off in defrost");
	no_early_def_a: assert property (
		($rose(s_r.st == ST_DEF) && !s_r.forced)
		|-> ($past(s_r.run_cnt) + 17'h00001 >= $past(period)))
		else $error("defrost before run period expired");
	defrost_limit_a: assert property (
		(s_r.st == ST_DEF && !s_r.forced_fix) |-> s_r.def_cnt < def_limit)
		else $error("defrost ran past its limit");
	forced_fix_a: assert property (
		s_r.forced_fix |-> s_r.def_cnt < FORCED_DEF_TICKS)
		else $error("fixed forced defrost too long");
	restart_zero_a: assert property (
		$fell(s_r.st == ST_DEF) |-> s_r.run_cnt == '0 && !s_r.accel)
		else $error("run period not restarted after defrost");
	retain_count_a: assert property (
		(s_r.st == ST_IDLE && $past(s_r.st) == ST_IDLE
		&& !$past(su.accel_req)) |-> $stable(s_r.run_cnt))
		else $error("run count lost while idle");
	forced_entry_a: assert property (
		(ce_in && su.forced_req && s_r.st == ST_HEAT
		&& heat_stage1_demand_in && !cool_any) |=> s_r.st == ST_DEF)
		else $error("forced defrost not entered");

	defrost_seen_c: cover property ($rose(s_r.st == ST_DEF));
	forced_fix_c: cover property ($rose(s_r.forced_fix));
	accel_done_c: cover property ($fell(s_r.accel));
endmodule

// ---- verif/stat_model.sv ----
// thermostat and service jumper stand-in for the sequencer bench
module stat_model
(
	// clock and commands
	input wire logic clk_in,
	input wire logic [1:0] call_in,
	input wire logic aux_in,
	input wire logic short_go_in,
	input wire logic [11:0] short_len_in,
	// unit side
	output logic cool1_out = 1'b0,
	output logic cool2_out = 1'b0,
	output logic heat1_out = 1'b0,
	output logic aux_out = 1'b0,
	output logic pin_a_out,
	output logic pin_b_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] cnt_r = 12'h000;
	// one call at a time: heat never rides with cool
	always @(posedge clk_in)
	begin
		cool1_out <= call_in inside {2'h1, 2'h2};
		cool2_out <= call_in == 2'h2;
		heat1_out <= call_in == 2'h3;
		aux_out <= aux_in;
		cnt_r <= short_go_in ? short_len_in : cnt_r - 12'(cnt_r != 12'h000);
	end
	// both pins high only while shorted
	assign pin_a_out = cnt_r != 12'h000;
	assign pin_b_out = cnt_r != 12'h000;
endmodule

// ---- verif/heat_pump_defrost_sequencer_tb.sv ----
// self-checking bench of the heat pump defrost sequencer
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_total++; \
	$display("Error at %0t: got %h expected %h", $time, g, e); end end
module heat_pump_defrost_sequencer_tb;
	import hp_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [1:0] call = 2'h0;
	logic aux = 1'b0;
	logic frost = 1'b0;
	logic sgo = 1'b0;
	logic [11:0] slen = 12'h000;
	logic c1, c2, h1, ax, pa, pb, valve, comp1, comp2, fan, eheat, hrdy, hresp;
	logic [31:0] hrdata;
	logic [31:0] got;
	logic [31:0] v;
	logic [31:0] exp_q[$];
	logic [31:0] exp_v;
	event seen;
	int err_total = 0;
	int comparisons = 0;
	wire logic [4:0] o = {valve, comp1, comp2, fan, eheat};
	localparam logic [4:0] IDLE_O = 5'h00;
	localparam logic [4:0] HEAT_O = 5'h0A;
	localparam logic [4:0] DEF_O = 5'h19;

	initial
	begin
		forever #5 clk_in = ~clk_in;
	end

	stat_model i_stat (.clk_in(clk_in), .call_in(call), .aux_in(aux),
		.short_go_in(sgo), .short_len_in(slen), .cool1_out(c1),
		.cool2_out(c2), .heat1_out(h1), .aux_out(ax), .pin_a_out(pa),
		.pin_b_out(pb));

	heat_pump_defrost_sequencer #(.TICK_CYCLES_P(4)) i_dut (
		.clk_in(clk_in), .rst_n_in(rst_n_in), .ce_in(1'b1),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(hrdata), .hreadyout_out(hrdy),
		.hresp_out(hresp), .cool_stage1_demand_in(c1),
		.cool_stage2_demand_in(c2), .heat_stage1_demand_in(h1),
		.aux_heat_demand_in(ax), .coil_frost_switch_in(frost),
		.speedup_pin_a_in(pa), .speedup_pin_b_in(pb),
		.valve_coil_out(valve), .compressor1_out(comp1),
		.compressor2_out(comp2), .outdoor_fan_out(fan),
		.electric_heat_out(eheat));

	// result watcher: oldest note against each captured value
	initial
	begin
		forever
		begin
			@(seen);
			// pop once: the macro names its expected value twice
			exp_v = exp_q.pop_front();
			`CHK(got, exp_v)
		end
	end

	task automatic note(input logic [31:0] e, input logic [31:0] g);
		exp_q.push_back(e);
		got = g;
		-> seen;
		@(posedge clk_in);
	endtask

	task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= HTRANS_NONSEQ;
		do @(posedge clk_in); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hrdy !== 1'b1);
		v = hrdata;
	endtask

	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		note(e, v);
	endtask

	// bounded wait for an output pattern
	task automatic reach(input logic [4:0] e, input int n);
		int k;
		k = 0;
		while (o !== e && k < n)
		begin
			@(posedge clk_in);
			k++;
		end
		note({27'h0, e}, {27'h0, o});
	endtask

	task automatic hold(input logic [4:0] e, input int n);
		logic [4:0] bad;
		bad = e;
		repeat (n)
		begin
			@(posedge clk_in);
			if (o !== e)
				bad = o;
		end
		note({27'h0, e}, {27'h0, bad});
	endtask

	task automatic short_pins(input int len);
		slen <= 12'(len);
		sgo <= 1'b1;
		@(posedge clk_in);
		sgo <= 1'b0;
		repeat (len + 2) @(posedge clk_in);
	endtask

	task automatic conclude();
		$display("errors %0d comparisons %0d", err_total, comparisons);
		if (err_total == 0 && comparisons > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	initial
	begin
		repeat (30000) @(posedge clk_in);
		err_total++;
		conclude();
	end

	initial
	begin
		void'($urandom(37852));
		repeat (10) @(posedge clk_in);
		rst_n_in <= 1'b1;
		@(posedge clk_in);
		hold(IDLE_O, 2);
		rd(CFG_OFS, 32'h1);
		rd(STATUS_OFS, 32'h1);
		note({31'h0, HRESP_OKAY}, {31'h0, hresp});
		for (int i = 0; i < 4; i++)
		begin
			bus(CFG_OFS, 1'b1, 32'(i));
			rd(CFG_OFS, 32'(i));
		end
		bus(32'h0000_000C, 1'b1, $urandom);
		rd(32'h0000_000C, 32'h0);
		bus(CFG_OFS, 1'b1, 32'h1);
		call <= 2'h1;
		reach(5'h1A, 8);
		call <= 2'h2;
		reach(5'h1E, 8);
		call <= 2'h0;
		reach(5'h10, 8);
		hold(5'h10, 20);
		call <= 2'h3;
		reach(HEAT_O, 8);
		aux <= 1'b1;
		reach(5'h0B, 8);
		aux <= 1'b0;
		call <= 2'h0;
		reach(IDLE_O, 8);
		hold(IDLE_O, 20);
		call <= 2'h3;
		frost <= 1'b1;
		reach(HEAT_O, 8);
		short_pins(4 + $urandom % 30);
		short_pins(140 + $urandom % 40);
		hold(HEAT_O, 300);
		rd(STATUS_OFS, 32'h84);
		short_pins(80);
		reach(DEF_O, 1000);
		rd(STATUS_OFS, 32'hB8);
		reach(HEAT_O, 1000);
		rd(STATUS_OFS, 32'h84);
		hold(HEAT_O, 2000);
		frost <= 1'b0;
		short_pins(400);
		reach(DEF_O, 60);
		rd(STATUS_OFS, 32'h58);
		hold(DEF_O, 1100);
		reach(HEAT_O, 200);
		rd(STATUS_OFS, 32'h04);
		hold(HEAT_O, 400);
		call <= 2'h0;
		reach(IDLE_O, 8);
		hold(IDLE_O, 400);
		bus(RUNCNT_OFS, 1'b0, 32'h0);
		note(32'h1, 32'(v >= 32'd95 && v <= 32'd110));
		call <= 2'h3;
		reach(HEAT_O, 8);
		bus(RUNCNT_OFS, 1'b0, 32'h0);
		note(32'h1, 32'(v >= 32'd95 && v <= 32'd112));
		// scaled period expires with the switch open: count restarts
		short_pins(80);
		hold(HEAT_O, 300);
		bus(RUNCNT_OFS, 1'b0, 32'h0);
		note(32'h1, 32'(v >= 32'd10 && v <= 32'd20));
		rd(STATUS_OFS, 32'h24);
		frost <= 1'b1;
		reach(DEF_O, 400);
		frost <= 1'b0;
		reach(HEAT_O, 8);
		rd(STATUS_OFS, 32'h04);
		// forced defrost with the switch closed ends on its opening
		frost <= 1'b1;
		short_pins(400);
		reach(DEF_O, 60);
		rd(STATUS_OFS, 32'hD8);
		frost <= 1'b0;
		reach(HEAT_O, 8);
		conclude();
	end
endmodule
